// *** src/sser_pkg.sv ***
package sser_pkg;

  // Command codes as the remote message decoder hands them over
  typedef enum logic [3:0] {
    SSER_CMD_NOP      = 4'b0000,
    SSER_CMD_RD_WCOND = 4'b0001,
    SSER_CMD_RD_WEVT  = 4'b0010,
    SSER_CMD_RD_WEN   = 4'b0011,
    SSER_CMD_WR_WEN   = 4'b0100,
    SSER_CMD_RD_ACOND = 4'b0101,
    SSER_CMD_RD_AEVT  = 4'b0110,
    SSER_CMD_RD_AEN   = 4'b0111,
    SSER_CMD_WR_AEN   = 4'b1000,
    SSER_CMD_CLS      = 4'b1001,
    SSER_CMD_PRESET   = 4'b1010,
    SSER_CMD_RD_ERR   = 4'b1011,
    SSER_CMD_RD_VER   = 4'b1100,
    SSER_CMD_RD_STB   = 4'b1101
  } sser_cmd_code_t;

  typedef struct packed {
    logic valid;
    sser_cmd_code_t code;
    logic [15:0] data;
  } sser_cmd_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } sser_rsp_t;

  localparam int SSER_REG_W = 16;
  localparam int SSER_NCOND = 3;
  // Warning group field positions
  localparam int SSER_WBIT_VOLT = 0;
  localparam int SSER_WBIT_CURR = 1;
  localparam int SSER_WBIT_OVERVOLT = 9;
  // Status byte field positions
  localparam int SSER_SB_ERRQ = 2;
  localparam int SSER_SB_WARN = 3;
  localparam int SSER_SB_RQS = 6;
  localparam int SSER_SB_ACT = 7;
  // Values after reset and fixed values
  localparam logic [15:0] SSER_ZERO16 = 16'h0000;
  localparam logic [7:0] SSER_ZERO8 = 8'h00;
  localparam logic [15:0] SSER_EN_MASK = 16'h7FFF;
  localparam logic [15:0] SSER_ERR_NONE = 16'h0000;
  localparam logic [15:0] SSER_ERR_OVF = 16'hFEA2;
  // Version in tenths: 1994.0 reads as 19940
  localparam logic [15:0] SSER_VERSION = 16'h4DE4;
  localparam int SSER_QDEPTH = 8;

endpackage

// *** src/sser_status.sv ***
`timescale 1ns/1ps
module sser_status
  import sser_pkg::*;
#(
  parameter int QDEPTH = SSER_QDEPTH
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire sser_cmd_t CMD,
  input wire logic VOLT_COND,
  input wire logic CURR_COND,
  input wire logic OVERVOLTAGE_PROTECT,
  input wire logic ERR_PUSH,
  input wire logic [15:0] ERR_CODE,
  output sser_rsp_t RSP,
  output logic [7:0] STATUS_SUMMARY_BYTE,
  output logic SRQ
);

  localparam int QAW = $clog2(QDEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // Condition inputs: three-stage synchroniser, change taken once the last two stages agree

  logic [SSER_NCOND-1:0] pin_in;
  logic [SSER_NCOND-1:0] s1_r;
  logic [SSER_NCOND-1:0] s2_r;
  logic [SSER_NCOND-1:0] s3_r;
  logic [SSER_NCOND-1:0] cond_r;
  logic [SSER_NCOND-1:0] rise;

  assign pin_in = {OVERVOLTAGE_PROTECT, CURR_COND, VOLT_COND};

  genvar gi;
  generate
    for (gi = 0; gi < SSER_NCOND; gi++) begin : g_sync
      always_ff @(posedge MCLK) begin
        if (!RST_N) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          s3_r[gi] <= 1'b0;
          cond_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= pin_in[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            cond_r[gi] <= s3_r[gi];
          end
        end
      end
      assign rise[gi] = (s2_r[gi] == s3_r[gi]) && s3_r[gi] && !cond_r[gi];
    end
  endgenerate

  // Place the three conditions in their field positions, all else zero
  function automatic logic [15:0] place(input logic [SSER_NCOND-1:0] v);
    logic [15:0] w;
    w = SSER_ZERO16;
    w[SSER_WBIT_VOLT] = v[0];
    w[SSER_WBIT_CURR] = v[1];
    w[SSER_WBIT_OVERVOLT] = v[2];
    return w;
  endfunction

  logic [15:0] wcond;
  logic [15:0] wrise;
  assign wcond = place(cond_r);
  assign wrise = place(rise);

  // Activity group reports nothing
  logic [15:0] acond;
  logic [15:0] aevt;
  assign acond = SSER_ZERO16;
  assign aevt = SSER_ZERO16;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  logic cmd_v;
  logic rd_wevt;
  logic do_cls;
  logic do_preset;
  logic rd_err;
  assign cmd_v = CMD.valid;
  assign rd_wevt = cmd_v && (CMD.code == SSER_CMD_RD_WEVT);
  assign do_cls = cmd_v && (CMD.code == SSER_CMD_CLS);
  assign do_preset = cmd_v && (CMD.code == SSER_CMD_PRESET);
  assign rd_err = cmd_v && (CMD.code == SSER_CMD_RD_ERR);

  ////////////////////////////////////////////////////////////////////////////
  // Warning event register

  logic [15:0] wevt_r;

  // A rise in the same cycle as a read or clear survives it
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      wevt_r <= SSER_ZERO16;
    end else if (rd_wevt || do_cls) begin
      wevt_r <= wrise;
    end else begin
      wevt_r <= wevt_r | wrise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable masks

  logic [15:0] wen_r;
  logic [15:0] aen_r;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      wen_r <= SSER_ZERO16;
      aen_r <= SSER_ZERO16;
    end else if (do_preset) begin
      wen_r <= SSER_ZERO16;
      aen_r <= SSER_ZERO16;
    end else if (cmd_v && CMD.code == SSER_CMD_WR_WEN) begin
      wen_r <= CMD.data & SSER_EN_MASK;
    end else if (cmd_v && CMD.code == SSER_CMD_WR_AEN) begin
      aen_r <= CMD.data & SSER_EN_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error and event queue

  logic [15:0] q_mem [QDEPTH];
  logic [QAW-1:0] q_head_r;
  logic [QAW-1:0] q_tail_r;
  logic [QAW:0] q_cnt_r;
  logic q_lock_r;
  logic q_empty;
  logic q_pop;
  logic q_push;
  logic q_last;
  logic [15:0] q_wdata;

  assign q_empty = (q_cnt_r == '0);
  assign q_pop = rd_err && !q_empty;
  // Once locked, nothing enters until a read or clear frees the queue
  assign q_push = ERR_PUSH && !q_lock_r && !do_cls;
  assign q_last = (q_cnt_r == (QAW+1)'(QDEPTH - 1)) && !q_pop;
  assign q_wdata = q_last ? SSER_ERR_OVF : ERR_CODE;

  always_ff @(posedge MCLK) begin
    if (q_push) begin
      q_mem[q_tail_r] <= q_wdata;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N || do_cls) begin
      q_head_r <= '0;
      q_tail_r <= '0;
      q_cnt_r <= '0;
      q_lock_r <= 1'b0;
    end else begin
      if (q_push) begin
        q_tail_r <= (q_tail_r == QAW'(QDEPTH - 1)) ? '0 : q_tail_r + QAW'(1);
      end
      if (q_pop) begin
        q_head_r <= (q_head_r == QAW'(QDEPTH - 1)) ? '0 : q_head_r + QAW'(1);
      end
      if (q_push && !q_pop) begin
        q_cnt_r <= q_cnt_r + (QAW+1)'(1);
      end else if (q_pop && !q_push) begin
        q_cnt_r <= q_cnt_r - (QAW+1)'(1);
      end
      if (q_pop) begin
        q_lock_r <= 1'b0;
      end else if (q_push && q_last) begin
        q_lock_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Summaries, status byte and service request

  logic wsum;
  logic asum;
  logic [7:0] sb_nxt;
  assign wsum = |(wevt_r & wen_r);
  assign asum = |(aevt & aen_r);

  always_comb begin
    sb_nxt = SSER_ZERO8;
    sb_nxt[SSER_SB_ERRQ] = !q_empty;
    sb_nxt[SSER_SB_WARN] = wsum;
    sb_nxt[SSER_SB_ACT] = asum;
    sb_nxt[SSER_SB_RQS] = wsum || asum || !q_empty;
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      STATUS_SUMMARY_BYTE <= SSER_ZERO8;
      SRQ <= 1'b0;
    end else begin
      STATUS_SUMMARY_BYTE <= sb_nxt;
      SRQ <= sb_nxt[SSER_SB_RQS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Query answers, one cycle after the command

  logic [15:0] rsp_nxt;
  logic rsp_v_nxt;

  always_comb begin
    rsp_v_nxt = cmd_v;
    rsp_nxt = SSER_ZERO16;
    case (CMD.code)
      SSER_CMD_RD_WCOND: rsp_nxt = wcond;
      SSER_CMD_RD_WEVT: rsp_nxt = wevt_r;
      SSER_CMD_RD_WEN: rsp_nxt = wen_r;
      SSER_CMD_RD_ACOND: rsp_nxt = acond;
      SSER_CMD_RD_AEVT: rsp_nxt = aevt;
      SSER_CMD_RD_AEN: rsp_nxt = aen_r;
      SSER_CMD_RD_ERR: rsp_nxt = q_empty ? SSER_ERR_NONE : q_mem[q_head_r];
      SSER_CMD_RD_VER: rsp_nxt = SSER_VERSION;
      SSER_CMD_RD_STB: rsp_nxt = {8'h00, STATUS_SUMMARY_BYTE};
      default: rsp_v_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      RSP <= '0;
    end else begin
      RSP.valid <= rsp_v_nxt;
      RSP.data <= rsp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_event_latch: assert property (@(posedge MCLK) disable iff (!RST_N)
    (wrise != 0) |=> ((wevt_r & $past(wrise)) == $past(wrise)))
    else $error("event bit missed a condition rise");

  chk_event_rdclr: assert property (@(posedge MCLK) disable iff (!RST_N)
    (rd_wevt && wrise == 0) |=> (wevt_r == 0) && (RSP.data == $past(wevt_r)))
    else $error("event read did not return and clear");

  chk_cls_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
    (do_cls && wrise == 0) |=> (wevt_r == 0) && (q_cnt_r == 0))
    else $error("clear status left events");

  chk_enable_bit15: assert property (@(posedge MCLK) disable iff (!RST_N)
    cmd_v && (CMD.code == SSER_CMD_WR_WEN) |=> (wen_r == ($past(CMD.data) & 16'h7FFF)))
    else $error("enable write kept bit 15 or was lost");

  chk_warn_summary: assert property (@(posedge MCLK) disable iff (!RST_N)
    ##1 STATUS_SUMMARY_BYTE[3] == $past(|(wevt_r & wen_r)))
    else $error("warning summary bit wrong");

  chk_act_zero: assert property (@(posedge MCLK) disable iff (!RST_N)
    cmd_v && (CMD.code == SSER_CMD_RD_AEVT) |=> RSP.valid && (RSP.data == 0))
    else $error("activity event read nonzero");

  chk_preset_masks: assert property (@(posedge MCLK) disable iff (!RST_N)
    do_preset |=> (wen_r == 0) && (aen_r == 0))
    else $error("preset left enable bits");

  chk_cond_keep: assert property (@(posedge MCLK) disable iff (!RST_N)
    cmd_v && (CMD.code == SSER_CMD_RD_WCOND) |=>
      (RSP.data == $past(wcond)) && (wevt_r == ($past(wevt_r) | $past(wrise))))
    else $error("condition read disturbed state");

  chk_err_empty: assert property (@(posedge MCLK) disable iff (!RST_N)
    rd_err && q_empty |=> RSP.valid && (RSP.data == 0))
    else $error("empty error query not zero");

  chk_version: assert property (@(posedge MCLK) disable iff (!RST_N)
    cmd_v && (CMD.code == SSER_CMD_RD_VER) |=> RSP.data == 16'h4DE4)
    else $error("version value wrong");

  chk_srq_follow: assert property (@(posedge MCLK) disable iff (!RST_N)
    ##1 SRQ == $past((|(wevt_r & wen_r)) || (|(aevt & aen_r)) || (q_cnt_r != 0)))
    else $error("service request does not follow the summaries");

  chk_ovf_lock: assert property (@(posedge MCLK) disable iff (!RST_N)
    q_lock_r && ERR_PUSH && !rd_err && !do_cls |=> q_cnt_r == $past(q_cnt_r))
    else $error("locked queue accepted an entry");

  chk_cond_track: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s1_r == s2_r) && (s2_r == s3_r) |=> cond_r == $past(s3_r))
    else $error("condition bits do not follow their inputs");

  chk_warn_layout: assert property (@(posedge MCLK) disable iff (!RST_N)
    wcond == {6'h00, cond_r[2], 7'h00, cond_r[1], cond_r[0]})
    else $error("warning condition bits out of place");

  chk_act_summary: assert property (@(posedge MCLK) disable iff (!RST_N)
    ##1 STATUS_SUMMARY_BYTE[7] == $past(|(aevt & aen_r)))
    else $error("activity summary bit wrong");

  chk_acond_zero: assert property (@(posedge MCLK) disable iff (!RST_N)
    cmd_v && (CMD.code == SSER_CMD_RD_ACOND) |=> RSP.valid && (RSP.data == 0))
    else $error("activity condition read nonzero");

  chk_ovf_marker: assert property (@(posedge MCLK) disable iff (!RST_N)
    q_push && q_last |=> q_lock_r && (q_cnt_r == (QAW+1)'(QDEPTH)))
    else $error("overflow marker did not lock the queue");

  chk_err_pop: assert property (@(posedge MCLK) disable iff (!RST_N)
    rd_err && !q_empty && !q_push |=> RSP.valid && (q_cnt_r == $past(q_cnt_r) - 1))
    else $error("error query did not remove an entry");

  chk_mask_bit15: assert property (@(posedge MCLK) disable iff (!RST_N)
    !wen_r[15] && !aen_r[15])
    else $error("enable mask bit 15 set");

  chk_event_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
    !rd_wevt && !do_cls |=> (wevt_r & $past(wevt_r)) == $past(wevt_r))
    else $error("event bit lost without read or clear");

endmodule

// *** tb/sser_host.sv ***
`timescale 1ns/1ps
module sser_host
  import sser_pkg::*;
(
  input wire logic mclk,
  output sser_cmd_t cmd,
  input wire sser_rsp_t rsp
);
  initial cmd = '0;
  // One command per call; the answer stands a single cycle, so it is taken at once
  task automatic send(input sser_cmd_code_t c, input logic [15:0] d, output sser_rsp_t r);
    cmd <= '{valid: 1'b1, code: c, data: d};
    @(posedge mclk);
    cmd <= '{valid: 1'b0, code: SSER_CMD_NOP, data: ~d};
    #1;
    r = rsp;
    @(posedge mclk);
  endtask
endmodule

// *** tb/scpi_status_event_reporting_test.sv ***
`timescale 1ns/1ps
module scpi_status_event_reporting_test;
  import sser_pkg::*;
  localparam int QD = 4;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic volt = 1'b0;
  logic curr = 1'b0;
  logic overvolt = 1'b0;
  logic push = 1'b0;
  logic [15:0] code = 16'h0000;
  sser_cmd_t cmd;
  sser_rsp_t rsp;
  logic [7:0] stb;
  logic srq;
  int err_count = 0;
  int n_compared = 0;
  initial forever #25 mclk = ~mclk;
  sser_host host_u (.mclk(mclk), .cmd(cmd), .rsp(rsp));
  sser_status #(.QDEPTH(QD)) dut_u (.MCLK(mclk), .RST_N(rst_n), .CMD(cmd),
    .VOLT_COND(volt), .CURR_COND(curr), .OVERVOLTAGE_PROTECT(overvolt), .ERR_PUSH(push),
    .ERR_CODE(code), .RSP(rsp), .STATUS_SUMMARY_BYTE(stb), .SRQ(srq));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic q(input sser_cmd_code_t c, input logic [15:0] exp, input string what);
    sser_rsp_t r;
    host_u.send(c, 16'h0000, r);
    chk("answer valid", 16'h0001, {15'h0, r.valid});
    chk(what, exp, r.data);
  endtask
  task automatic w(input sser_cmd_code_t c, input logic [15:0] d);
    sser_rsp_t r;
    host_u.send(c, d, r);
  endtask
  // Registered outputs are looked at once the edge's updates have landed
  task automatic sb(input logic [7:0] exp);
    #1;
    chk("status byte", {8'h00, exp}, {8'h00, stb});
    chk("srq", {15'h0, exp[SSER_SB_RQS]}, {15'h0, srq});
    @(posedge mclk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    q(SSER_CMD_RD_WCOND, 16'h0000, "warning condition");
    q(SSER_CMD_RD_WEVT, 16'h0000, "warning event");
    q(SSER_CMD_RD_WEN, 16'h0000, "warning enable");
    q(SSER_CMD_RD_AEN, 16'h0000, "activity enable");
    q(SSER_CMD_RD_VER, SSER_VERSION, "version");
    q(SSER_CMD_RD_ERR, SSER_ERR_NONE, "empty error queue");
    q(SSER_CMD_RD_STB, 16'h0000, "status byte query");
    sb(8'h00);
  endtask
  task automatic t_enable();
    w(SSER_CMD_WR_WEN, 16'hFFFF);
    q(SSER_CMD_RD_WEN, 16'h7FFF, "warning enable");
    w(SSER_CMD_WR_AEN, 16'hFFFF);
    q(SSER_CMD_RD_AEN, 16'h7FFF, "activity enable");
    w(SSER_CMD_PRESET, 16'h0000);
    q(SSER_CMD_RD_WEN, 16'h0000, "warning enable after preset");
    q(SSER_CMD_RD_AEN, 16'h0000, "activity enable after preset");
  endtask
  task automatic t_events();
    volt <= 1'b1;
    repeat (6) @(posedge mclk);
    q(SSER_CMD_RD_WCOND, 16'h0001, "voltage condition");
    q(SSER_CMD_RD_WEVT, 16'h0001, "voltage event");
    volt <= 1'b0;
    curr <= 1'b1;
    repeat (6) @(posedge mclk);
    q(SSER_CMD_RD_WCOND, 16'h0002, "current condition");
    curr <= 1'b0;
    repeat (6) @(posedge mclk);
    q(SSER_CMD_RD_WCOND, 16'h0000, "fallen condition");
    q(SSER_CMD_RD_WCOND, 16'h0000, "condition reread");
    q(SSER_CMD_RD_WEVT, 16'h0002, "latched current event");
    q(SSER_CMD_RD_WEVT, 16'h0000, "event after read");
    q(SSER_CMD_RD_ACOND, 16'h0000, "activity condition");
    q(SSER_CMD_RD_AEVT, 16'h0000, "activity event");
  endtask
  task automatic t_summary();
    overvolt <= 1'b1;
    repeat (8) @(posedge mclk);
    sb(8'h00);
    w(SSER_CMD_WR_WEN, 16'h7DFF);
    sb(8'h00);
    w(SSER_CMD_WR_WEN, 16'h0200);
    sb(8'h48);
    w(SSER_CMD_CLS, 16'h0000);
    sb(8'h00);
    q(SSER_CMD_RD_WEVT, 16'h0000, "event after clear");
    q(SSER_CMD_RD_WCOND, 16'h0200, "overvoltage condition");
    overvolt <= 1'b0;
  endtask
  task automatic t_queue();
    for (int i = 1; i <= QD + 1; i++) begin
      push <= 1'b1;
      code <= 16'h8000 + 16'(i);
      @(posedge mclk);
    end
    push <= 1'b0;
    code <= 16'h0000;
    @(posedge mclk);
    sb(8'h44);
    for (int i = 1; i < QD; i++) begin
      q(SSER_CMD_RD_ERR, 16'h8000 + 16'(i), "oldest error");
    end
    q(SSER_CMD_RD_ERR, SSER_ERR_OVF, "overflow marker");
    q(SSER_CMD_RD_ERR, SSER_ERR_NONE, "drained queue");
    sb(8'h00);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // The run needs some 110 cycles; this is far beyond that
  initial begin
    #150000;
    err_count++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_enable();
    t_events();
    t_summary();
    t_queue();
    conclude();
  end
endmodule
